/* shared/timer_pkg.sv */
// What this block does
// RULE1: Two independent 16-bit reloadable timers
// RULE2: Count upward; wrap from all ones to zero
// RULE3: Prescaler divides system clock by 1..128
// RULE4: Reload one, prescale one: shortest time-out
// RULE5: Reload zero, prescale 128: full-wrap longest time-out
// RULE6: One-shot: interrupt, count to one, self-disable
// RULE7: One-shot output inverts one clock at reload
// RULE8: One-shot/continuous count the prescaled system clock
// RULE9: Continuous: interrupt, count to one, keep counting
// RULE10: Periodic modes toggle output at each reload
// RULE11: Start count for first pass; restart at one
// RULE12: Counter mode counts pin edges, polarity picks edge
// RULE13: Counter mode: interrupt, count to one, continue
// RULE14: Edge setting sets initial output level always
// RULE15: Counted input at most quarter clock, two-period phases
// RULE16: Comparator counter counts comparator edges, no prescaler
// RULE17: Software loads count one before enabling counters
// RULE18: PWM toggles output at match, reloads to one
// RULE19: Polarity one: start high, low at match
// RULE20: Polarity zero: start low, high at match
// RULE21: Software inverts polarity after start for level change
// RULE22: Software configures fully before setting enable last
// RULE23: Interrupt is one-clock pulse per reload event
// RULE24: Pin and comparator synchronized before edge detection
package timer_pkg;

   localparam int unsigned NUM_TIMERS = 2;
   localparam int unsigned CNT_W = 16;
   localparam int unsigned PRE_W = 7;
   localparam int unsigned ADDR_W = 6;
   localparam int unsigned DATA_W = 32;

   localparam logic [CNT_W-1:0] COUNT_RESTART = 16'h0001;

   // --------------------------------------------------------------
   // Register map
   // --------------------------------------------------------------
   localparam int unsigned ADDR_UNMAPPED_BIT = 5;
   localparam int unsigned ADDR_TIMER_BIT = 4;
   localparam int unsigned ADDR_REG_MSB = 3;
   localparam int unsigned ADDR_REG_LSB = 2;
   localparam logic [1:0] REG_CTRL = 2'h0;
   localparam logic [1:0] REG_COUNT = 2'h1;
   localparam logic [1:0] REG_RELOAD = 2'h2;
   localparam logic [1:0] REG_PWM = 2'h3;

   // --------------------------------------------------------------
   // Control register fields
   // --------------------------------------------------------------
   localparam int unsigned CTRL_EN_BIT = 0;
   localparam int unsigned CTRL_MODE_LSB = 1;
   localparam int unsigned CTRL_MODE_MSB = 3;
   localparam int unsigned CTRL_PRE_LSB = 4;
   localparam int unsigned CTRL_PRE_MSB = 6;
   localparam int unsigned CTRL_POL_BIT = 7;
   localparam int unsigned CTRL_OUTEN_BIT = 8;

   localparam logic [2:0] MODE_ONE_SHOT = 3'h0;
   localparam logic [2:0] MODE_CONTINUOUS = 3'h1;
   localparam logic [2:0] MODE_COUNTER = 3'h2;
   localparam logic [2:0] MODE_CMP_COUNTER = 3'h3;
   localparam logic [2:0] MODE_PWM_SINGLE = 3'h4;

   typedef struct packed {
      logic out_en;
      logic output_polarity_select;
      logic [2:0] prescale;
      logic [2:0] mode;
      logic en;
   } ctrl_type;

   typedef struct packed {
      ctrl_type ctrl;
      logic [CNT_W-1:0] count;
      logic [CNT_W-1:0] reload;
      logic [CNT_W-1:0] pwm;
      logic [PRE_W-1:0] pre;
      logic level;
      logic pin_s1;
      logic pin_s2;
      logic pin_prev;
      logic irq;
      logic tout;
      logic tout_oe;
   } timer_type;

endpackage : timer_pkg

/* design/reload_timer.sv */
// Added by the designer: the register offsets and register access over Avalon-MM.
`timescale 1ns/100ps
module reload_timer
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Avalon-MM slave
   input wire logic [timer_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [timer_pkg::DATA_W-1:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [timer_pkg::DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   // Pins and comparator
   input wire logic [timer_pkg::NUM_TIMERS-1:0] timer_in,
   input wire logic cmp_out,
   output logic [timer_pkg::NUM_TIMERS-1:0] timer_out,
   output logic [timer_pkg::NUM_TIMERS-1:0] timer_out_oe,
   // Interrupt requests
   output logic [timer_pkg::NUM_TIMERS-1:0] timer_irq
);

   typedef struct packed {
      timer_pkg::timer_type [timer_pkg::NUM_TIMERS-1:0] tmr;
      logic cmp_s1;
      logic cmp_s2;
      logic cmp_prev;
      logic waitrequest;
      logic [timer_pkg::DATA_W-1:0] readdata;
   } state_type;

   state_type s_r;
   state_type s_nxt;

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   function automatic logic [timer_pkg::PRE_W-1:0] pre_mask(input logic [2:0] p);
      pre_mask = timer_pkg::PRE_W'((8'h01 << p) - 8'h01);
   endfunction : pre_mask

   function automatic logic edge_seen(input logic pol, input logic now, input logic prev);
      edge_seen = pol ? (now & ~prev) : (~now & prev);
   endfunction : edge_seen

   function automatic logic [timer_pkg::DATA_W-1:0] reg_value(input timer_pkg::timer_type t,
                                                           input logic [1:0] idx);
      reg_value = '0;
      case (idx)
         timer_pkg::REG_CTRL: reg_value = timer_pkg::DATA_W'(t.ctrl);
         timer_pkg::REG_COUNT: reg_value = timer_pkg::DATA_W'(t.count);
         timer_pkg::REG_RELOAD: reg_value = timer_pkg::DATA_W'(t.reload);
         timer_pkg::REG_PWM: reg_value = timer_pkg::DATA_W'(t.pwm);
         default: reg_value = '0;
      endcase
   endfunction : reg_value

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
      merge16 = old;
      if (be[0])
      begin
         merge16[7:0] = wd[7:0];
      end
      if (be[1])
      begin
         merge16[15:8] = wd[15:8];
      end
   endfunction : merge16

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb
   begin
      timer_pkg::timer_type cur;
      timer_pkg::timer_type nt;
      logic cmp_edge;
      logic tick;
      logic evt;
      logic hit;
      logic [15:0] ctrl_bits;
      logic sel;
      logic [1:0] idx;
      cur = '0;
      nt = '0;
      cmp_edge = 1'b0;
      tick = 1'b0;
      evt = 1'b0;
      ctrl_bits = '0;
      hit = ~avs_address[timer_pkg::ADDR_UNMAPPED_BIT];
      sel = avs_address[timer_pkg::ADDR_TIMER_BIT];
      idx = avs_address[timer_pkg::ADDR_REG_MSB:timer_pkg::ADDR_REG_LSB];
      s_nxt = s_r;

      // Comparator synchronizer, shared by both timers
      s_nxt.cmp_s1 = cmp_out; // RULE24
      s_nxt.cmp_s2 = s_r.cmp_s1;
      s_nxt.cmp_prev = s_r.cmp_s2;

      for (int i = 0; i < int'(timer_pkg::NUM_TIMERS); i++) // RULE1
      begin
         cur = s_r.tmr[i];
         nt = cur;
         nt.irq = 1'b0;
         nt.pin_s1 = timer_in[i]; // RULE24
         nt.pin_s2 = cur.pin_s1;
         nt.pin_prev = cur.pin_s2;
         cmp_edge = edge_seen(cur.ctrl.output_polarity_select, s_r.cmp_s2, s_r.cmp_prev);
         evt = 1'b0;

         // Count source per mode
         case (cur.ctrl.mode)
            timer_pkg::MODE_COUNTER:
            begin
               tick = edge_seen(cur.ctrl.output_polarity_select, cur.pin_s2,
                                cur.pin_prev); // RULE12
            end
            timer_pkg::MODE_CMP_COUNTER:
            begin
               tick = cmp_edge; // RULE16
            end
            default:
            begin
               tick = (cur.pre == pre_mask(cur.ctrl.prescale)); // RULE3 RULE8
            end
         endcase

         if (!cur.ctrl.en)
         begin
            nt.pre = '0;
            nt.level = cur.ctrl.output_polarity_select; // RULE14 RULE19 RULE20
         end
         else
         begin
            nt.pre = tick ? '0 : timer_pkg::PRE_W'(cur.pre + 1'b1);
            if (tick)
            begin
               if (cur.count == cur.reload) // RULE4 RULE5
               begin
                  evt = 1'b1;
                  nt.irq = 1'b1; // RULE23
                  nt.count = timer_pkg::COUNT_RESTART; // RULE11
                  case (cur.ctrl.mode)
                     timer_pkg::MODE_ONE_SHOT:
                     begin
                        nt.ctrl.en = 1'b0; // RULE6
                        nt.level = cur.ctrl.output_polarity_select;
                     end
                     timer_pkg::MODE_PWM_SINGLE:
                     begin
                        nt.level = cur.ctrl.output_polarity_select; // RULE18 RULE19 RULE20
                     end
                     default:
                     begin
                        nt.level = ~cur.level; // RULE9 RULE10 RULE13
                     end
                  endcase
               end
               else
               begin
                  nt.count = timer_pkg::CNT_W'(cur.count + 1'b1); // RULE2
                  if (cur.ctrl.mode == timer_pkg::MODE_PWM_SINGLE && cur.count == cur.pwm)
                  begin
                     nt.level = ~cur.level; // RULE18
                  end
               end
            end
         end

         // Pin drive: one-shot reload shows a single inverted cycle
         if (evt && cur.ctrl.mode == timer_pkg::MODE_ONE_SHOT)
         begin
            nt.tout = ~cur.level; // RULE7
         end
         else
         begin
            nt.tout = nt.level;
         end
         nt.tout_oe = cur.ctrl.out_en;

         // Register writes take effect at the accepted edge and win
         if (avs_write && !s_r.waitrequest && hit && sel == i[0])
         begin
            case (idx)
               timer_pkg::REG_CTRL:
               begin
                  ctrl_bits = merge16(16'(cur.ctrl), avs_writedata, avs_byteenable);
                  nt.ctrl.en = ctrl_bits[timer_pkg::CTRL_EN_BIT];
                  nt.ctrl.mode = ctrl_bits[timer_pkg::CTRL_MODE_MSB:timer_pkg::CTRL_MODE_LSB];
                  nt.ctrl.prescale = ctrl_bits[timer_pkg::CTRL_PRE_MSB:timer_pkg::CTRL_PRE_LSB];
                  nt.ctrl.output_polarity_select = ctrl_bits[timer_pkg::CTRL_POL_BIT];
                  nt.ctrl.out_en = ctrl_bits[timer_pkg::CTRL_OUTEN_BIT];
               end
               timer_pkg::REG_COUNT:
               begin
                  nt.count = merge16(cur.count, avs_writedata, avs_byteenable); // RULE11
               end
               timer_pkg::REG_RELOAD:
               begin
                  nt.reload = merge16(cur.reload, avs_writedata, avs_byteenable);
               end
               default:
               begin
                  nt.pwm = merge16(cur.pwm, avs_writedata, avs_byteenable);
               end
            endcase
         end
         s_nxt.tmr[i] = nt;
      end

      // ----------------------------------------------------------------
      // Avalon handshake: one wait cycle, then accept
      // ----------------------------------------------------------------
      if (s_r.waitrequest)
      begin
         if (avs_read || avs_write)
         begin
            s_nxt.waitrequest = 1'b0;
            s_nxt.readdata = (avs_read && hit) ? reg_value(s_r.tmr[sel], idx) : '0;
         end
      end
      else
      begin
         s_nxt.waitrequest = 1'b1;
         s_nxt.readdata = '0;
      end
   end

   // ------------------------------------------------------------------
   // State register
   // ------------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         s_r <= '0;
         s_r.waitrequest <= 1'b1;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign avs_readdata = s_r.readdata;
   assign avs_waitrequest = s_r.waitrequest;

   for (genvar g = 0; g < int'(timer_pkg::NUM_TIMERS); g++)
   begin : g_out
      assign timer_out[g] = s_r.tmr[g].tout;
      assign timer_out_oe[g] = s_r.tmr[g].tout_oe;
      assign timer_irq[g] = s_r.tmr[g].irq;
   end

endmodule : reload_timer

/* bench/timer_checker.sv */
`timescale 1ns/100ps
module timer_checker
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Register bus
   input wire logic [timer_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [timer_pkg::DATA_W-1:0] avs_readdata,
   input wire logic avs_waitrequest,
   // Timer pins and requests
   input wire logic [1:0] timer_out,
   input wire logic [1:0] timer_out_oe,
   input wire logic [1:0] timer_irq
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // ----------
   // Bus
   // ----------
   chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");
   chk_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest) else $error("request not answered");
   chk_idle_zero: assert property (avs_waitrequest |-> avs_readdata == '0)
      else $error("readdata not zero when idle");
   chk_unmapped_zero: assert property (avs_read && avs_address[5] && !avs_waitrequest
      |-> avs_readdata == '0) else $error("unmapped read not zero");
   // ----------
   // Timers
   // ----------
   chk_oe_held: assert property ((!(avs_write && !avs_waitrequest)) ##1 1'b1
      |=> $stable(timer_out_oe)) else $error("enable changed without write");
   chk_rst_quiet: assert property ($rose(rst_n) |-> timer_irq == '0 && timer_out == '0)
      else $error("outputs not cleared by reset");
   chk_irq0_pulse: assert property (timer_irq[0] |=> !timer_irq[0])
      else $error("irq0 longer than a cycle");
   chk_irq1_pulse: assert property (timer_irq[1] |=> !timer_irq[1])
      else $error("irq1 longer than a cycle");
   cov_irq0: cover property (timer_irq[0]);
   cov_irq1: cover property (timer_irq[1]);
   cov_out: cover property ($changed(timer_out[1]));
endmodule : timer_checker

bind reload_timer timer_checker chk_u (.*);

/* bench/edge_source.sv */
`timescale 1ns/100ps
module edge_source
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Lines to toggle
   input wire logic [2:0] run,
   // Pin and comparator lines
   output logic [1:0] timer_in,
   output logic cmp_out
);
   logic [1:0] ph_r;
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         ph_r <= 2'h0;
         {cmp_out, timer_in} <= 3'h0;
      end
      else
      begin
         ph_r <= (ph_r == 2'h2) ? 2'h0 : ph_r + 2'h1;
         if (ph_r == 2'h2)
         begin
            {cmp_out, timer_in} <= {cmp_out, timer_in} ^ run;
         end
      end
   end
endmodule : edge_source

/* bench/test_reloadable_timer_pwm_counter.sv */
`timescale 1ns/100ps
module test_reloadable_timer_pwm_counter;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [timer_pkg::ADDR_W-1:0] avs_address = '0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [timer_pkg::DATA_W-1:0] avs_writedata = '0;
   logic [3:0] avs_byteenable = 4'hf;
   logic [timer_pkg::DATA_W-1:0] avs_readdata;
   logic avs_waitrequest;
   logic [1:0] timer_in;
   logic cmp_out;
   logic [1:0] timer_out;
   logic [1:0] timer_out_oe;
   logic [1:0] timer_irq;
   logic [2:0] run = 3'h0;
   logic [31:0] q;
   int miscompares = 0;
   int samples_checked = 0;
   int seed = 32'h8680c0b1;
   int irq_a = 0;
   int irq_b = 0;

   reload_timer dut_u (.*);
   edge_source far_u (.*);

   always #25 clk = ~clk;

   always @(posedge clk)
   begin
      irq_a <= irq_a + timer_irq[0];
      irq_b <= irq_b + timer_irq[1];
   end

   // ----------
   // Helpers
   // ----------
   task automatic finish_test();
      $display("checked %0d bad %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : finish_test

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
      samples_checked++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("BAD %0t %s: %h not %h", $time, m, seen, exp);
      end
   endtask : check

   task automatic bus(input logic wr, input logic [5:0] a, input logic [15:0] d);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= {16'h0000, d};
      avs_write <= wr;
      avs_read <= ~wr;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0 && n < 20)
      begin
         n++;
         @(posedge clk);
      end
      check(32'(n < 20), 1, "bus answer");
      if (n >= 20)
         finish_test();
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk);
   endtask : bus

   task automatic wait_irq(input int t, output int n);
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (timer_irq[t] !== 1'b1 && n < 3000);
      check(32'(n < 3000), 1, "irq wait");
      if (n >= 3000)
         finish_test();
   endtask : wait_irq

   function automatic logic [15:0] ctrl(logic [2:0] m, logic [2:0] p, logic pl);
      return {7'h00, 1'b1, pl, p, m, 1'b0};
   endfunction : ctrl

   function automatic int first(logic [15:0] r, logic [15:0] s, int p);
      return (int'(16'(r - s)) + 1) << p;
   endfunction : first

   task automatic setup(input int t, input logic [15:0] c, s, r, w);
      logic [5:0] b;
      b = 6'(t * 16);
      bus(1, b, c);
      bus(1, b | 6'h04, s);
      bus(1, b | 6'h0c, w);
      bus(1, b | 6'h08, r);
      bus(1, b, c | 16'h0001);
   endtask : setup

   // ----------
   // Scenarios
   // ----------
   initial
   begin
      logic [15:0] v;
      logic pl;
      int n, m, p, r, w, a, b;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 8; i++)
      begin
         bus(0, 6'(i * 4), 0);
         check(q, 0, "reset value");
         v = 16'($random(seed)) & ((i % 4 == 0) ? 16'h01fe : 16'hffff);
         bus(1, 6'(i * 4), v);
         bus(0, 6'(i * 4), 0);
         check(q, {16'h0000, v}, "readback");
      end
      bus(1, 6'h20, 16'hffff);
      bus(0, 6'h20, 0);
      check(q, 0, "unmapped");
      $display("registers done");
      for (int i = 0; i < 2; i++)
      begin
         p = $unsigned($random(seed)) % 3;
         r = 2 + $unsigned($random(seed)) % 8;
         v = i ? 16'hfffe : 16'h0001;
         setup(0, ctrl(timer_pkg::MODE_CONTINUOUS, 3'(p), 0), v, 16'(r), 0);
         wait_irq(0, n);
         check(n, first(16'(r), v, p), "first pass");
         pl = timer_out[0];
         wait_irq(0, n);
         check(n, r << p, "period");
         check(timer_out[0], !pl, "toggle");
      end
      $display("continuous done");
      pl = 1'($random(seed));
      setup(1, ctrl(timer_pkg::MODE_ONE_SHOT, 0, pl), 1, 1, 0);
      wait_irq(1, n);
      check(n, 1, "shortest");
      check(timer_out[1], !pl, "pulse");
      @(posedge clk);
      check(timer_out[1], pl, "pulse end");
      bus(0, 6'h10, 0);
      check(q, ctrl(timer_pkg::MODE_ONE_SHOT, 0, pl), "self disable");
      bus(0, 6'h14, 0);
      check(q, 1, "count one");
      repeat (20) @(posedge clk);
      check(irq_b, 1, "single shot");
      setup(1, ctrl(timer_pkg::MODE_ONE_SHOT, 0, pl), 1, 16'h0028, 0);
      bus(1, 6'h10, ctrl(timer_pkg::MODE_ONE_SHOT, 0, !pl) | 16'h0001);
      wait_irq(1, n);
      check(timer_out[1], !pl, "flip at time-out");
      repeat (4) @(posedge clk);
      check(timer_out[1], !pl, "level kept");
      $display("one-shot done");
      setup(0, ctrl(timer_pkg::MODE_COUNTER, 0, 1), 1, 3, 0);
      setup(1, ctrl(timer_pkg::MODE_CMP_COUNTER, 0, 0), 1, 3, 0);
      check(timer_out, 2'h1, "start level");
      check(timer_out_oe, 2'h3, "output enable");
      a = irq_a;
      b = irq_b;
      run <= 3'h5;
      repeat (36) @(posedge clk);
      run <= 3'h0;
      repeat (12) @(posedge clk);
      check(irq_a - a, 2, "pin edges");
      check(irq_b - b, 2, "comparator edges");
      bus(0, 6'h04, 0);
      check(q, 1, "counter reload");
      $display("counter done");
      for (int k = 0; k < 2; k++)
      begin
         r = 6 + $unsigned($random(seed)) % 8;
         w = 1 + $unsigned($random(seed)) % (r - 1);
         setup(1, ctrl(timer_pkg::MODE_PWM_SINGLE, 0, k[0]), 1, 16'(r), 16'(w));
         wait_irq(1, n);
         m = 0;
         repeat (r)
         begin
            @(posedge clk);
            m += timer_out[1];
         end
         check(m, k ? w : r - w, "duty");
         wait_irq(1, n);
         check(n, r, "pwm period");
      end
      $display("pwm done");
      finish_test();
   end
endmodule : test_reloadable_timer_pwm_counter
